// ==== include/sie_regs.vh ====
// constants for the subtract execute block
// assumes inclusion by bare name from rtl files
`ifndef SIE_REGS_VH
`define SIE_REGS_VH
`define SIE_OP_SUBL 8'h08
`define SIE_OP_SUBR 6'h17
`define SIE_IDX_MAX 8'h5F
`define SIE_ACC_HI_BASE 8'h60
`define SIE_BANK_ACC_LO 4'h0
`define SIE_BANK_ACC_HI 4'hF
`define SIE_Q1 2'h0
`define SIE_Q2 2'h1
`define SIE_Q3 2'h2
`define SIE_Q4 2'h3
`define SIE_W_RST 8'h00
`define SIE_FLAG_N 4
`define SIE_FLAG_OV 3
`define SIE_FLAG_Z 2
`define SIE_FLAG_DC 1
`define SIE_FLAG_C 0
`define SIE_OP_HI 15
`define SIE_SUBL_LO 8
`define SIE_SUBR_LO 10
`define SIE_D_BIT 9
`define SIE_A_BIT 8
`define SIE_F_HI 7
`define SIE_NIB_HI 3
`define SIE_NIB_CARRY 4
`define SIE_SIGN_BIT 7
`define SIE_BORROW_BIT 8
`define SIE_ONE9 9'h001
`define SIE_ONE5 5'h01
`define SIE_ZERO8 8'h00
`define SIE_IR_RST 16'h0000
`define SIE_ADDR_RST 12'h000
`define SIE_BYTE_RST 8'h00
`define SIE_STAT_RST 5'h00
`endif

// ==== rtl/sie_subtract_exec.v ====
// subtract instruction execute: literal_minus_accumulator and register_minus_accumulator
// assumes a core that presents one instruction word per four-phase cycle and a
// data memory with combinational read data
// Functional notes
// - literal minus working register into working register
// - decode upper byte 08h, low byte literal
// - both update N, overflow, carry, nibble carry, Z
// - literal form: one word, one four-phase cycle
// - register form: register minus working register
// - destination bit 0 working, 1 register
// - access bit 0 access bank, 1 bank pointer
// - extended set and access 0: indexed offset
// - indexed only when address at most 5Fh
// - register form: one word, one cycle, four phases
// - carry is inverted borrow; zero sets Z
`timescale 1ns/1ps
`include "sie_regs.vh"
module sie_subtract_exec (
  // clock and reset
  input wire ref_clk_i,
  input wire rst_n_i,
  // instruction stream
  input wire instr_valid_i,
  input wire [15:0] instr_i,
  input wire ext_set_en_i,
  input wire [3:0] bank_pointer_i,
  input wire [11:0] index_base_i,
  // data memory
  input wire [7:0] mem_rdata_i,
  output reg [11:0] mem_addr_o,
  output reg [7:0] mem_wdata_o,
  output reg mem_we_o,
  // core state
  output reg [7:0] w_o,
  output reg [4:0] status_o,
  output reg [1:0] phase_o,
  output reg done_o
);
  localparam S_IDLE = 1'b0;
  localparam S_RUN = 1'b1;

  // sequencing state
  reg state_reg;
  reg state_next;
  reg [1:0] phase_next;
  reg done_next;

  // latched instruction word and operand
  reg [15:0] ir_reg;
  reg [15:0] ir_next;
  reg [7:0] opnd_reg;
  reg [7:0] opnd_next;

  // arithmetic
  reg [7:0] lhs;
  reg [8:0] diff;
  reg [4:0] nib;
  reg flag_c;
  reg flag_dc;
  reg flag_z;
  reg flag_n;
  reg flag_ov;

  // next values of the result outputs
  reg [11:0] addr_next;
  reg [11:0] mem_addr_next;
  reg [7:0] mem_wdata_next;
  reg mem_we_next;
  reg [7:0] w_next;
  reg [4:0] status_next;

  // instruction field decode
  wire is_subl = (ir_reg[`SIE_OP_HI:`SIE_SUBL_LO] == `SIE_OP_SUBL);
  wire is_subr = (ir_reg[`SIE_OP_HI:`SIE_SUBR_LO] == `SIE_OP_SUBR);
  wire is_sub = is_subl | is_subr;
  wire acc_banked = ir_reg[`SIE_A_BIT];
  wire dest_is_reg = ir_reg[`SIE_D_BIT];
  wire [7:0] fadr = ir_reg[`SIE_F_HI:0];
  wire running = (state_reg == S_RUN);

  // operand address formation
  always @* begin
    addr_next = {bank_pointer_i, fadr};
    if (!acc_banked) begin
      if (ext_set_en_i && fadr <= `SIE_IDX_MAX)
        addr_next = index_base_i + {`SIE_BANK_ACC_LO, fadr};
      else if (fadr >= `SIE_ACC_HI_BASE)
        addr_next = {`SIE_BANK_ACC_HI, fadr};
      else
        addr_next = {`SIE_BANK_ACC_LO, fadr};
    end
  end

  // minuend minus working register, two's complement via inverted add
  always @* begin
    lhs = is_subl ? ir_reg[`SIE_F_HI:0] : opnd_reg;
    diff = {1'b0, lhs} + {1'b0, ~w_o} + `SIE_ONE9;
    nib = {1'b0, lhs[`SIE_NIB_HI:0]} + {1'b0, ~w_o[`SIE_NIB_HI:0]} + `SIE_ONE5;
    // carry out of the inverted add means no borrow was needed
    flag_c = diff[`SIE_BORROW_BIT];
    flag_dc = nib[`SIE_NIB_CARRY];
    flag_z = (diff[`SIE_F_HI:0] == `SIE_ZERO8);
    flag_n = diff[`SIE_SIGN_BIT];
    flag_ov = (lhs[`SIE_SIGN_BIT] != w_o[`SIE_SIGN_BIT]) &&
              (diff[`SIE_SIGN_BIT] != lhs[`SIE_SIGN_BIT]);
  end

  // four-phase sequencer; words offered while busy are dropped silently
  always @* begin
    state_next = state_reg;
    phase_next = phase_o;
    done_next = 1'b0;
    ir_next = ir_reg;
    case (state_reg)
      S_IDLE: begin
        phase_next = `SIE_Q1;
        if (instr_valid_i) begin
          ir_next = instr_i;
          state_next = S_RUN;
        end
      end
      S_RUN: begin
        case (phase_o)
          `SIE_Q1: phase_next = `SIE_Q2;
          `SIE_Q2: phase_next = `SIE_Q3;
          `SIE_Q3: phase_next = `SIE_Q4;
          `SIE_Q4: begin
            phase_next = `SIE_Q1;
            state_next = S_IDLE;
            done_next = 1'b1;
          end
          default: phase_next = `SIE_Q1;
        endcase
      end
      default: state_next = S_IDLE;
    endcase
  end

  // per-phase datapath work
  always @* begin
    opnd_next = opnd_reg;
    mem_addr_next = mem_addr_o;
    mem_wdata_next = mem_wdata_o;
    mem_we_next = 1'b0;
    w_next = w_o;
    status_next = status_o;
    if (running) begin
      case (phase_o)
        `SIE_Q1: begin
          mem_addr_next = addr_next;
        end
        `SIE_Q2: begin
          // read data is combinational from the address set in Q1
          opnd_next = is_subl ? ir_reg[`SIE_F_HI:0] : mem_rdata_i;
        end
        `SIE_Q3: begin
          mem_wdata_next = diff[`SIE_F_HI:0];
          // other opcodes still latch the difference into mem_wdata_o but leave the flags alone
          if (is_sub) begin
            status_next[`SIE_FLAG_C] = flag_c;
            status_next[`SIE_FLAG_DC] = flag_dc;
            status_next[`SIE_FLAG_Z] = flag_z;
            status_next[`SIE_FLAG_N] = flag_n;
            status_next[`SIE_FLAG_OV] = flag_ov;
          end
        end
        `SIE_Q4: begin
          if (is_subl) begin
            w_next = mem_wdata_o;
          end else if (is_subr) begin
            if (dest_is_reg)
              mem_we_next = 1'b1;
            else
              w_next = mem_wdata_o;
          end
        end
        default: mem_we_next = 1'b0;
      endcase
    end
  end

  // sequencer registers
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= S_IDLE;
      phase_o <= `SIE_Q1;
      done_o <= 1'b0;
      ir_reg <= `SIE_IR_RST;
    end else begin
      state_reg <= state_next;
      phase_o <= phase_next;
      done_o <= done_next;
      ir_reg <= ir_next;
    end
  end

  // operand and memory-side registers
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      opnd_reg <= `SIE_BYTE_RST;
      mem_addr_o <= `SIE_ADDR_RST;
      mem_wdata_o <= `SIE_BYTE_RST;
      mem_we_o <= 1'b0;
    end else begin
      opnd_reg <= opnd_next;
      mem_addr_o <= mem_addr_next;
      mem_wdata_o <= mem_wdata_next;
      mem_we_o <= mem_we_next;
    end
  end

  // architectural state registers
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      w_o <= `SIE_W_RST;
      status_o <= `SIE_STAT_RST;
    end else begin
      w_o <= w_next;
      status_o <= status_next;
    end
  end
endmodule

// ==== bench/sie_props.sv ====
// port checker for the subtract execute block
// assumes binding onto sie_subtract_exec
`timescale 1ns/1ps
module sie_props(
  input wire ref_clk_i, rst_n_i, instr_valid_i, mem_we_o, done_o,
  input wire [1:0] phase_o,
  input wire [4:0] status_o,
  input wire [7:0] w_o, mem_wdata_o,
  input wire [11:0] mem_addr_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_take_done: assert property (instr_valid_i && phase_o==0 |-> ##[4:5] done_o) else $error("late");
  a_phase_walk: assert property (phase_o==1 |=> phase_o==2 ##1 phase_o==3 ##1 done_o) else $error("walk");
  a_done_pulse: assert property (done_o |=> !done_o) else $error("done");
  a_write_done: assert property (mem_we_o |-> done_o && $stable(w_o)) else $error("we");
  a_flags_write: assert property (mem_we_o |-> status_o[2]==(mem_wdata_o==0) && status_o[4]==mem_wdata_o[7])
    else $error("flags");
  a_status_hold: assert property (phase_o!=2 |=> $stable(status_o)) else $error("status");
  a_addr_hold: assert property (phase_o==2 |=> $stable(mem_addr_o)) else $error("addr");
  a_wdata_hold: assert property (mem_we_o |-> $stable(mem_wdata_o)) else $error("wdata");
endmodule
bind sie_subtract_exec sie_props chk(
  .ref_clk_i(ref_clk_i),
  .rst_n_i(rst_n_i),
  .instr_valid_i(instr_valid_i),
  .mem_we_o(mem_we_o),
  .done_o(done_o),
  .phase_o(phase_o),
  .status_o(status_o),
  .w_o(w_o),
  .mem_wdata_o(mem_wdata_o),
  .mem_addr_o(mem_addr_o)
);

// ==== bench/tb.sv ====
// bench for sie_subtract_exec with an integer model
// assumes the checker is bound in
`timescale 1ns/1ps
module tb;
  reg ref_clk_i=0, rst_n_i=0, instr_valid_i=0, ext_set_en_i=0;
  reg [15:0] instr_i=0;
  reg [3:0] bank_pointer_i=0;
  reg [11:0] index_base_i=0;
  reg [7:0] mem_rdata_i=0;
  wire [11:0] mem_addr_o;
  wire [7:0] mem_wdata_o, w_o;
  wire [4:0] status_o;
  wire [1:0] phase_o;
  wire mem_we_o, done_o;
  integer failures=0, tests_run=0, n, i, t, d, a, f, m, r, ew=0, ad;
  reg [4:0] es=0;
  sie_subtract_exec uut(
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .instr_valid_i(instr_valid_i),
    .instr_i(instr_i),
    .ext_set_en_i(ext_set_en_i),
    .bank_pointer_i(bank_pointer_i),
    .index_base_i(index_base_i),
    .mem_rdata_i(mem_rdata_i),
    .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o),
    .mem_we_o(mem_we_o),
    .w_o(w_o),
    .status_o(status_o),
    .phase_o(phase_o),
    .done_o(done_o)
  );
  initial forever #50 ref_clk_i=~ref_clk_i;
  task chk(input [31:0] g, input [31:0] e);
    tests_run++;
    if (g!==e) begin
      failures++;
      $display("MISMATCH %0t %h %h", $time, g, e);
    end
  endtask
  task finish_test;
    if (failures==0 && tests_run>0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    finish_test;
  end
  initial begin
    n=$urandom(30977);
    repeat(20) @(posedge ref_clk_i);
    #1 rst_n_i=1;
    for (n=0; n<60; n++) begin
      // kind 2 is an unrelated opcode that must leave state alone
      t=$urandom%3; d=$urandom%2; a=$urandom%2; f=$urandom%256;
      ext_set_en_i=$urandom; bank_pointer_i=$urandom; index_base_i=$urandom; mem_rdata_i=$urandom;
      // force a zero result now and then
      if (n%6==0) begin f=ew; mem_rdata_i=ew; end
      m=(t==1) ? mem_rdata_i : f;
      r=(m-ew)&255;
      if (t!=2) es={r[7], m[7]!=ew[7] && r[7]!=m[7], r==0, m%16>=ew%16, m>=ew};
      ad=a ? bank_pointer_i*256+f : (ext_set_en_i && f<96) ? (index_base_i+f)%4096 : f<96 ? f : 3840+f;
      instr_i=(t==1) ? {6'h17,d[0],a[0],f[7:0]} : (t==0) ? {8'h08,f[7:0]} : {8'h00,f[7:0]};
      instr_valid_i=1;
      @(posedge ref_clk_i) #1 instr_valid_i=0;
      // mid-run reset while an instruction is in flight
      if (n==30) begin
        @(posedge ref_clk_i) #1 rst_n_i=0;
        #1 chk(w_o, 0);
        chk(status_o, 0);
        chk(phase_o, 0);
        chk(done_o, 0);
        ew=0;
        es=0;
        @(posedge ref_clk_i) #1 rst_n_i=1;
        continue;
      end
      for (i=0; i<9 && done_o!==1'b1; i++) @(posedge ref_clk_i) #1;
      chk(done_o, 1);
      chk(phase_o, 0);
      chk(status_o, es);
      chk(mem_we_o, t==1 && d);
      if (t==1) chk(mem_addr_o, ad);
      if (t!=2) chk(mem_wdata_o, r);
      if (t==0 || (t==1 && !d)) ew=r;
      chk(w_o, ew);
    end
    finish_test;
  end
endmodule
